// *** hw/scfd_cfg.svh ***
// constants of the sequence current fault detector
// Contract
// - Assert when zero-sequence magnitude rose over 0.04 rated versus two cycles earlier.
// - Assert when negative-sequence magnitude rose over 0.04 rated versus two cycles earlier.
// - Assert when positive-sequence magnitude grew over 25% versus two cycles earlier.
// - Keep a two-cycle history of each sequence magnitude for the comparisons.
// - An increment activation stays sealed for two cycles after detection.
// - After the two-cycle seal, the output stays asserted 30 ms more.
// - Assert on phase selector ground-fault or two-phase-fault indication.
// - Ignore phase selector indications while an open pole is present.
// - Level activation needs positive seq above 0.02 rated or zero seq above 0.05.
// - Once asserted, hold output while any overcurrent pickup is active.
// - No enable or control input; the detector always operates.
// - One fault-detected output, also recorded as an event.
`ifndef SCFD_CFG_SVH
`define SCFD_CFG_SVH

`define SCFD_MAG_W          16
`define SCFD_NCH            3
`define SCFD_CH_ZERO        0
`define SCFD_CH_NEG         1
`define SCFD_CH_POS         2
`define SCFD_OC_UNITS       3

`define SCFD_SAMPLES_PER_CYC 16
`define SCFD_HIST_CYCLES    2
`define SCFD_HIST_DEPTH     (`SCFD_SAMPLES_PER_CYC * `SCFD_HIST_CYCLES)
`define SCFD_FILL_W         6
`define SCFD_SEAL_SAMPLES   6'h20

`define SCFD_PERMILLE       32'h3E8
`define SCFD_PERCENT        32'h64
`define SCFD_I0_INC_PM      32'h28
`define SCFD_I2_INC_PM      32'h28
`define SCFD_I1_INC_PCT     32'h19
`define SCFD_I1_SUP_PCT     32'h2
`define SCFD_I0_SUP_PCT     32'h5

`define SCFD_CLK_KHZ        100000
`define SCFD_RESET_TIME_MS  30
`define SCFD_HOLD_CLKS      (`SCFD_RESET_TIME_MS * `SCFD_CLK_KHZ)
`define SCFD_HOLD_W         22

`endif

// *** hw/scfd_pkg.sv ***
// types of the sequence current fault detector
`include "scfd_cfg.svh"
package scfd_pkg;
    typedef logic [`SCFD_MAG_W-1:0] scfd_mag_t;

    typedef enum logic [1:0] {
        SCFD_ST_IDLE   = 2'b00,
        SCFD_ST_SEAL   = 2'b01,
        SCFD_ST_HOLD   = 2'b10,
        SCFD_ST_PICKUP = 2'b11
    } scfd_inc_state_t;

    typedef struct packed {
        scfd_mag_t [`SCFD_NCH-1:0][`SCFD_HIST_DEPTH-1:0] mem;
        logic [`SCFD_FILL_W-1:0]                           fill;
        logic                                              full;
    } scfd_hist_state_t;

    typedef struct packed {
        scfd_inc_state_t          fsm;
        logic [`SCFD_FILL_W-1:0]  seal_cnt;
        logic [`SCFD_HOLD_W-1:0]  hold_cnt;
        logic                     lvl_sealed;
        logic                     fd;
        logic                     fd_event;
    } scfd_top_state_t;
endpackage

// *** hw/scfd_if.sv ***
// carrier between the detector core and its magnitude history
`timescale 1ns/10ps
`default_nettype none
`include "scfd_cfg.svh"
interface scfd_if;
    logic                                    sample_valid;
    scfd_pkg::scfd_mag_t [`SCFD_NCH-1:0]     mag_new;
    scfd_pkg::scfd_mag_t [`SCFD_NCH-1:0]     mag_old;
    logic                                    hist_full;

    modport feed (
        output sample_valid,
        output mag_new,
        input  mag_old,
        input  hist_full
    );
    modport hist (
        input  sample_valid,
        input  mag_new,
        output mag_old,
        output hist_full
    );
endinterface
`default_nettype wire

// *** hw/scfd_hist.sv ***
// two-cycle history line of the three sequence magnitudes
`timescale 1ns/10ps
`default_nettype none
`include "scfd_cfg.svh"
module scfd_hist (
    input  wire logic  mclk,
    input  wire logic  resetn,
    scfd_if.hist       hif
);
    scfd_pkg::scfd_hist_state_t st_reg;
    scfd_pkg::scfd_hist_state_t st_next;

    genvar gc;
    generate
        for (gc = 0; gc < `SCFD_NCH; gc = gc + 1) begin : g_ch
            // oldest entry is the sample taken two cycles before the new one
            assign hif.mag_old[gc] = st_reg.mem[gc][`SCFD_HIST_DEPTH-1];
        end
    endgenerate
    assign hif.hist_full = st_reg.full;

    always_comb begin
        st_next = st_reg;
        if (hif.sample_valid) begin
            for (int c = 0; c < `SCFD_NCH; c++) begin
                st_next.mem[c] = {st_reg.mem[c][`SCFD_HIST_DEPTH-2:0], hif.mag_new[c]};
            end
            if (!st_reg.full) begin
                st_next.fill = st_reg.fill + 6'h01;
                st_next.full = (st_reg.fill == 6'(`SCFD_HIST_DEPTH - 1));
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    AST_HIST_SHIFT: assert property (@(posedge mclk) disable iff (!resetn)
        hif.sample_valid |=> st_reg.mem[0][1] == $past(st_reg.mem[0][0]))
        else $error("history line did not shift");
endmodule
`default_nettype wire

// *** hw/scfd_top.sv ***
// sequence current fault detector core
`timescale 1ns/10ps
`default_nettype none
`include "scfd_cfg.svh"
module scfd_top #(
    parameter int unsigned HOLD_CYCLES = `SCFD_HOLD_CLKS
) (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        sample_valid,
    input  wire logic [`SCFD_MAG_W-1:0]      i0_mag,
    input  wire logic [`SCFD_MAG_W-1:0]      i2_mag,
    input  wire logic [`SCFD_MAG_W-1:0]      i1_mag,
    input  wire logic [`SCFD_MAG_W-1:0]      rated_current,
    input  wire logic                        ground_fault,
    input  wire logic                        two_phase_fault,
    input  wire logic                        open_pole,
    input  wire logic [`SCFD_OC_UNITS-1:0]   phase_inst_overcurrent_pickup,
    input  wire logic [`SCFD_OC_UNITS-1:0]   phase_timed_overcurrent_pickup,
    input  wire logic [`SCFD_OC_UNITS-1:0]   ground_inst_overcurrent_pickup,
    input  wire logic [`SCFD_OC_UNITS-1:0]   ground_timed_overcurrent_pickup,
    input  wire logic [`SCFD_OC_UNITS-1:0]   negseq_inst_overcurrent_pickup,
    input  wire logic [`SCFD_OC_UNITS-1:0]   negseq_timed_overcurrent_pickup,
    output logic                             fault_detected_out,
    output logic                             fault_event_out
);
    localparam logic [`SCFD_HOLD_W-1:0] HOLD_M1 = `SCFD_HOLD_W'(HOLD_CYCLES - 1);

    scfd_pkg::scfd_top_state_t st_reg;
    scfd_pkg::scfd_top_state_t st_next;

    logic [31:0] rated_w;
    logic [31:0] th_zero_inc;
    logic [31:0] th_neg_inc;
    logic [31:0] th_pos_sup;
    logic [31:0] th_zero_sup;
    logic        inc_zero;
    logic        inc_neg;
    logic        inc_pos;
    logic        inc_any;
    logic        supervised;
    logic        selector_act;
    logic        lvl_act;
    logic        pickup_any;
    scfd_pkg::scfd_mag_t [`SCFD_NCH-1:0] mag_old;
    logic        hist_full;

    scfd_if hif ();

    assign hif.sample_valid                  = sample_valid;
    assign hif.mag_new[`SCFD_CH_ZERO]        = i0_mag;
    assign hif.mag_new[`SCFD_CH_NEG]         = i2_mag;
    assign hif.mag_new[`SCFD_CH_POS]         = i1_mag;
    assign mag_old                           = hif.mag_old;
    assign hist_full                         = hif.hist_full;

    scfd_hist u_hist (
        .mclk   (mclk),
        .resetn (resetn),
        .hif    (hif)
    );

    // thresholds scaled to rated current, compared without division
    assign rated_w     = {16'h0000, rated_current};
    assign th_zero_inc = rated_w * `SCFD_I0_INC_PM;
    assign th_neg_inc  = rated_w * `SCFD_I2_INC_PM;
    assign th_pos_sup  = rated_w * `SCFD_I1_SUP_PCT;
    assign th_zero_sup = rated_w * `SCFD_I0_SUP_PCT;

    // increments against the stored magnitude two cycles back
    assign inc_zero = (i0_mag > mag_old[`SCFD_CH_ZERO]) &&
        ({16'h0000, 16'(i0_mag - mag_old[`SCFD_CH_ZERO])} * `SCFD_PERMILLE > th_zero_inc);
    assign inc_neg  = (i2_mag > mag_old[`SCFD_CH_NEG]) &&
        ({16'h0000, 16'(i2_mag - mag_old[`SCFD_CH_NEG])} * `SCFD_PERMILLE > th_neg_inc);
    assign inc_pos  = ({16'h0000, i1_mag} * `SCFD_PERCENT) >
        ({16'h0000, mag_old[`SCFD_CH_POS]} * (`SCFD_PERCENT + `SCFD_I1_INC_PCT));
    // no comparison until the line holds two full cycles
    assign inc_any  = sample_valid & hist_full & (inc_zero | inc_neg | inc_pos);

    // minimum current supervision of the level path
    assign supervised = (({16'h0000, i1_mag} * `SCFD_PERCENT) > th_pos_sup) ||
                        (({16'h0000, i0_mag} * `SCFD_PERCENT) > th_zero_sup);
    assign selector_act = (ground_fault | two_phase_fault) & ~open_pole;
    assign lvl_act      = selector_act & supervised;

    assign pickup_any = (|phase_inst_overcurrent_pickup)  |
                        (|phase_timed_overcurrent_pickup) |
                        (|ground_inst_overcurrent_pickup) |
                        (|ground_timed_overcurrent_pickup) |
                        (|negseq_inst_overcurrent_pickup) |
                        (|negseq_timed_overcurrent_pickup);

    always_comb begin
        st_next = st_reg;
        case (st_reg.fsm)
            scfd_pkg::SCFD_ST_IDLE: begin
                st_next.fsm = scfd_pkg::SCFD_ST_IDLE;
            end
            scfd_pkg::SCFD_ST_SEAL: begin
                if (sample_valid) begin
                    if (st_reg.seal_cnt == 6'h01) begin
                        st_next.fsm      = scfd_pkg::SCFD_ST_HOLD;
                        st_next.hold_cnt = HOLD_M1;
                        st_next.seal_cnt = 6'h00;
                    end else begin
                        st_next.seal_cnt = st_reg.seal_cnt - 6'h01;
                    end
                end
            end
            scfd_pkg::SCFD_ST_HOLD: begin
                if (st_reg.hold_cnt == '0) begin
                    if (pickup_any) begin
                        st_next.fsm = scfd_pkg::SCFD_ST_PICKUP;
                    end else begin
                        st_next.fsm = scfd_pkg::SCFD_ST_IDLE;
                    end
                end else begin
                    st_next.hold_cnt = st_reg.hold_cnt - 22'h000001;
                end
            end
            scfd_pkg::SCFD_ST_PICKUP: begin
                if (!pickup_any) begin
                    st_next.fsm = scfd_pkg::SCFD_ST_IDLE;
                end
            end
            default: begin
                st_next.fsm = scfd_pkg::SCFD_ST_IDLE;
            end
        endcase
        // a fresh increment restarts the two-cycle seal
        if (inc_any) begin
            st_next.fsm      = scfd_pkg::SCFD_ST_SEAL;
            st_next.seal_cnt = `SCFD_SEAL_SAMPLES;
            st_next.hold_cnt = '0;
        end
        st_next.lvl_sealed = lvl_act | (st_reg.lvl_sealed & pickup_any);
        // always in operation: no enable gates the output
        st_next.fd = (st_next.fsm != scfd_pkg::SCFD_ST_IDLE) | st_next.lvl_sealed;
        st_next.fd_event = st_next.fd & ~st_reg.fd;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fault_detected_out = st_reg.fd;
    assign fault_event_out    = st_reg.fd_event;

    AST_ZERO_INC: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full && inc_zero) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL) && fault_detected_out)
        else $error("zero sequence increment did not assert output");

    AST_NEG_INC: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full && inc_neg) |=>
            (st_reg.seal_cnt == `SCFD_SEAL_SAMPLES) && fault_detected_out)
        else $error("negative sequence increment did not assert output");

    AST_POS_INC: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full && inc_pos) |=> fault_detected_out)
        else $error("positive sequence increment did not assert output");

    AST_NO_CMP_UNFILLED: assert property (@(posedge mclk) disable iff (!resetn)
        (!hist_full && st_reg.fsm == scfd_pkg::SCFD_ST_IDLE) |=>
            st_reg.fsm != scfd_pkg::SCFD_ST_SEAL)
        else $error("increment compared before history filled");

    AST_SEAL_HOLDS: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL && !sample_valid) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL) && $stable(st_reg.seal_cnt))
        else $error("seal left without a sample");

    AST_HOLD_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL && st_reg.seal_cnt == 6'h01 &&
         sample_valid && !inc_any) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD) && (st_reg.hold_cnt == HOLD_M1) &&
            fault_detected_out)
        else $error("extra reset time not started after seal");

    AST_HOLD_ASSERTED: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD) |-> fault_detected_out)
        else $error("output released during extra reset time");

    AST_SELECTOR_ACT: assert property (@(posedge mclk) disable iff (!resetn)
        (ground_fault && !open_pole && supervised) |=> fault_detected_out)
        else $error("ground fault indication did not assert output");

    AST_OPEN_POLE: assert property (@(posedge mclk) disable iff (!resetn)
        (open_pole && !st_reg.lvl_sealed) |=> !st_reg.lvl_sealed)
        else $error("selector indication accepted during open pole");

    AST_SUPERVISION: assert property (@(posedge mclk) disable iff (!resetn)
        (!supervised && !st_reg.lvl_sealed) |=> !st_reg.lvl_sealed)
        else $error("level path activated without current supervision");

    AST_PICKUP_SEAL: assert property (@(posedge mclk) disable iff (!resetn)
        (fault_detected_out && pickup_any) |=> fault_detected_out)
        else $error("output dropped while overcurrent pickup active");

    AST_EVENT: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(fault_detected_out) |-> fault_event_out ##1 !fault_event_out)
        else $error("fault event not recorded on rising output");

    AST_TWO_PHASE_ACT: assert property (@(posedge mclk) disable iff (!resetn)
        (two_phase_fault && !open_pole && supervised) |=>
            fault_detected_out)
        else $error("two phase fault indication did not assert output");

    AST_LEVEL_SEALS: assert property (@(posedge mclk) disable iff (!resetn)
        lvl_act |=>
            st_reg.lvl_sealed)
        else $error("level activation not sealed");

    AST_OPEN_POLE_DROP: assert property (@(posedge mclk) disable iff (!resetn)
        (open_pole && !pickup_any) |=>
            !st_reg.lvl_sealed)
        else $error("level path held during open pole");

    AST_ZERO_SUP_ACT: assert property (@(posedge mclk) disable iff (!resetn)
        (two_phase_fault && !open_pole &&
         ({16'h0000, i0_mag} * 32'h14 > {16'h0000, rated_current})) |=>
            fault_detected_out)
        else $error("zero sequence supervision did not allow activation");

    AST_POS_SUP_ACT: assert property (@(posedge mclk) disable iff (!resetn)
        (ground_fault && !open_pole &&
         ({16'h0000, i1_mag} * 32'h32 > {16'h0000, rated_current})) |=>
            fault_detected_out)
        else $error("positive sequence supervision did not allow activation");

    AST_ZERO_STEP: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full && (i0_mag > mag_old[`SCFD_CH_ZERO]) &&
         ({16'h0000, 16'(i0_mag - mag_old[`SCFD_CH_ZERO])} * 32'h19 >
          {16'h0000, rated_current})) |=>
            fault_detected_out)
        else $error("zero sequence step did not assert output");

    AST_NEG_STEP: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full && (i2_mag > mag_old[`SCFD_CH_NEG]) &&
         ({16'h0000, 16'(i2_mag - mag_old[`SCFD_CH_NEG])} * 32'h19 >
          {16'h0000, rated_current})) |=>
            fault_detected_out)
        else $error("negative sequence step did not assert output");

    AST_POS_STEP: assert property (@(posedge mclk) disable iff (!resetn)
        (sample_valid && hist_full &&
         ({16'h0000, i1_mag} * 32'h4 > {16'h0000, mag_old[`SCFD_CH_POS]} * 32'h5)) |=>
            fault_detected_out)
        else $error("positive sequence growth did not assert output");

    AST_HIST_FULL_STAYS: assert property (@(posedge mclk) disable iff (!resetn)
        hist_full |=>
            hist_full)
        else $error("history lost its filled state");

    AST_SEAL_ASSERTED: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL) |->
            fault_detected_out)
        else $error("output released during seal");

    AST_SEAL_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL && sample_valid && st_reg.seal_cnt != 6'h01 &&
         !inc_any) |=> (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL) &&
            (st_reg.seal_cnt == $past(st_reg.seal_cnt) - 6'h01))
        else $error("seal did not count one sample");

    AST_RESEAL: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm != scfd_pkg::SCFD_ST_IDLE && inc_any) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_SEAL) && (st_reg.seal_cnt == `SCFD_SEAL_SAMPLES))
        else $error("fresh increment did not restart seal");

    AST_HOLD_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD && st_reg.hold_cnt != '0 && !inc_any) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD) &&
            (st_reg.hold_cnt == $past(st_reg.hold_cnt) - 22'h000001))
        else $error("extra reset time did not count down");

    AST_HOLD_END_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD && st_reg.hold_cnt == '0 && !pickup_any &&
         !inc_any) |=> (st_reg.fsm == scfd_pkg::SCFD_ST_IDLE))
        else $error("increment path not released after extra reset time");

    AST_HOLD_END_PICKUP: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_HOLD && st_reg.hold_cnt == '0 && pickup_any &&
         !inc_any) |=> (st_reg.fsm == scfd_pkg::SCFD_ST_PICKUP) && fault_detected_out)
        else $error("pickup did not seal increment path");

    AST_PICKUP_ASSERTED: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_PICKUP) |->
            fault_detected_out)
        else $error("output low while pickup seal held");

    AST_PICKUP_RELEASE: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_PICKUP && !pickup_any && !inc_any) |=>
            (st_reg.fsm == scfd_pkg::SCFD_ST_IDLE))
        else $error("pickup seal not released");

    AST_LVL_SEAL_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.lvl_sealed && pickup_any) |=>
            st_reg.lvl_sealed)
        else $error("level seal dropped while pickup active");

    AST_LEVEL_DROP: assert property (@(posedge mclk) disable iff (!resetn)
        (st_reg.fsm == scfd_pkg::SCFD_ST_IDLE && !inc_any && !lvl_act && !pickup_any) |=>
            !fault_detected_out)
        else $error("output held with no activation source");

    AST_EVENT_ONLY_RISE: assert property (@(posedge mclk) disable iff (!resetn)
        fault_event_out |->
            (fault_detected_out && !$past(fault_detected_out)))
        else $error("fault event without a rising output");
endmodule
`default_nettype wire

// *** tb/scfd_partner.sv ***
// model of the phase selector and overcurrent elements feeding the detector
`timescale 1ns/10ps
`default_nettype none
module scfd_partner (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic [20:0] req,
    output logic      [20:0] drive
);
    logic [20:0] near_reg;
    logic [20:0] far_reg;

    // indications come out of registered logic, one or two cycles late
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            near_reg <= '0;
            far_reg  <= '0;
        end else begin
            near_reg <= req;
            far_reg  <= near_reg;
        end
    end

    assign drive = slow ? far_reg : near_reg;
endmodule
`default_nettype wire

// *** tb/scfd_tb_top.sv ***
// self-checking bench of the sequence current fault detector
`timescale 1ns/10ps
`default_nettype none
`include "scfd_cfg.svh"
module scfd_tb_top;
    localparam int HOLD = 20;
    logic                   mclk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   sample_valid = 1'b0;
    logic [`SCFD_MAG_W-1:0] mag [3] = '{16'h0, 16'h0, 16'h0};
    logic [`SCFD_MAG_W-1:0] base [3];
    logic [`SCFD_MAG_W-1:0] rated = 16'h3E8;
    logic                   slow = 1'b0;
    logic [2:0]             cmd = 3'h0;
    logic [17:0]            pk_cmd = 18'h0;
    wire logic [20:0]       drive;
    logic                   fd;
    logic                   fev;
    int                     cyc = 0;
    int                     fail_count = 0;
    int                     checks_done = 0;
    int                     seed = 29;
    int                     exp_q[$];

    always #5 mclk = ~mclk;

    always @(posedge mclk) cyc <= cyc + 1;

    scfd_partner partner_u (
        .mclk   (mclk),
        .resetn (resetn),
        .slow   (slow),
        .req    ({pk_cmd, cmd}),
        .drive  (drive)
    );

    scfd_top #(.HOLD_CYCLES(HOLD)) dut_u (
        .mclk                            (mclk),
        .resetn                          (resetn),
        .sample_valid                    (sample_valid),
        .i0_mag                          (mag[0]),
        .i2_mag                          (mag[1]),
        .i1_mag                          (mag[2]),
        .rated_current                   (rated),
        .ground_fault                    (drive[0]),
        .two_phase_fault                 (drive[1]),
        .open_pole                       (drive[2]),
        .phase_inst_overcurrent_pickup   (drive[5:3]),
        .phase_timed_overcurrent_pickup  (drive[8:6]),
        .ground_inst_overcurrent_pickup  (drive[11:9]),
        .ground_timed_overcurrent_pickup (drive[14:12]),
        .negseq_inst_overcurrent_pickup  (drive[17:15]),
        .negseq_timed_overcurrent_pickup (drive[20:18]),
        .fault_detected_out              (fd),
        .fault_event_out                 (fev)
    );

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // every event pulse is matched against the oldest expected rise cycle
    always @(negedge mclk) begin
        if (fev === 1'b1) begin
            check("output with event", {31'h0, fd}, 32'h1);
            if (exp_q.size() == 0) begin
                check("unexpected event", 32'h1, 32'h0);
            end else begin
                check("event cycle", cyc, exp_q.pop_front());
            end
        end
    end

    // level path: indications, supervision, then pickup seal and release
    task automatic lvl(input logic [2:0] c, input int i1, input int i0, input logic fire,
                       input logic [17:0] pk, input logic sl);
        @(posedge mclk);
        slow <= sl;
        sample_valid <= 1'b0;
        cmd <= c;
        pk_cmd <= pk;
        mag[2] <= 16'(i1);
        mag[0] <= 16'(i0);
        if (fire) exp_q.push_back(cyc + 3 + int'(sl));
        repeat (4) @(posedge mclk);
        @(negedge mclk) check("level detect", {31'h0, fd}, {31'h0, fire});
        @(posedge mclk) cmd <= 3'h0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) check("pickup seal", {31'h0, fd}, {31'h0, fire && pk != 0});
        @(posedge mclk) pk_cmd <= 18'h0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) check("level release", {31'h0, fd}, 32'h0);
    endtask

    // increment path: settle history, one-sample spike, seal, hold, release
    task automatic inc(input int ch, input int delta, input logic fire, input logic [17:0] pk);
        int n;
        @(posedge mclk);
        slow <= 1'b0;
        sample_valid <= 1'b1;
        for (n = 0; n < 3; n++) mag[n] <= base[n];
        repeat (100) @(posedge mclk);
        @(negedge mclk) check("quiet before spike", {31'h0, fd}, 32'h0);
        @(posedge mclk);
        mag[ch] <= base[ch] + 16'(delta);
        pk_cmd <= pk;
        if (fire) exp_q.push_back(cyc + 2);
        @(posedge mclk) mag[ch] <= base[ch];
        // two cycles of samples sealed, then the extra hold time
        for (n = 0; n < `SCFD_HIST_DEPTH + HOLD; n++) begin
            @(negedge mclk);
            check("seal and hold", {31'h0, fd}, {31'h0, fire});
        end
        @(negedge mclk) check("hold end", {31'h0, fd}, {31'h0, fire && pk != 0});
        @(posedge mclk) pk_cmd <= 18'h0;
        repeat (3) @(posedge mclk);
        @(negedge mclk) check("increment release", {31'h0, fd}, 32'h0);
    endtask

    initial begin
        int g;
        for (g = 0; g < 3; g++) base[g] = 16'(4 * (60 + ($random(seed) & 63)));
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        for (g = 0; g < 6; g++) begin
            lvl(3'h1, 21, 0, 1'b1, 18'h1 << (3 * g + (($random(seed) & 32'h7FFF) % 3)), g[0]);
        end
        lvl(3'h1, 20, 0, 1'b0, 18'h0, 1'b0);
        lvl(3'h2, 0, 51, 1'b1, 18'h0, 1'b1);
        lvl(3'h2, 0, 50, 1'b0, 18'h0, 1'b0);
        lvl(3'h5, 500, 0, 1'b0, 18'h0, 1'b0);
        lvl(3'h6, 0, 500, 1'b0, 18'h0, 1'b0);
        lvl(3'h3, 21, 51, 1'b1, 18'h0, 1'b0);
        lvl(3'h0, 500, 500, 1'b0, 18'h3FFFF, 1'b0);
        inc(0, 41, 1'b1, 18'h0);
        inc(0, 40, 1'b0, 18'h0);
        inc(1, 41, 1'b1, 18'h1 << (($random(seed) & 32'h7FFF) % 18));
        inc(1, 40, 1'b0, 18'h0);
        inc(2, base[2] / 4 + 1, 1'b1, 18'h0);
        inc(2, base[2] / 4, 1'b0, 18'h0);
        // thresholds scale with rated current
        @(posedge mclk) rated <= 16'h7D0;
        lvl(3'h1, 41, 0, 1'b1, 18'h0, 1'b0);
        lvl(3'h1, 40, 0, 1'b0, 18'h0, 1'b0);
        inc(0, 81, 1'b1, 18'h0);
        inc(0, 80, 1'b0, 18'h0);
        check("pending events", exp_q.size(), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
